// ---- bench/ir_primary_model.sv ----
/*
 * Behavioural primary station: frames bytes with begin, check and end characters.
 * Assumes the caller runs send from a thread synchronised to the clock.
 */
`timescale 1ns/1ps

module ir_primary_model (
	input wire logic i_core_clk,
	output logic [7:0] o_byte,
	output logic o_byte_valid,
	output logic o_active,
	output ir_link_pkg::frame_kind_t o_kind,
	output logic [ir_link_pkg::SLOT_W-1:0] o_slot,
	output logic [7:0] o_addr,
	output logic o_ready
);
	import ir_link_pkg::*;

	// ==========================================
	// idle values, then an encoder that stalls one cycle in four
	initial
	begin
		o_byte = 8'h00;
		o_byte_valid = 1'b0;
		o_active = 1'b0;
		o_kind = fk_other;
		o_slot = 4'h0;
		o_addr = 8'h00;
	end
	always @(posedge i_core_clk)
		o_ready <= #1 ($urandom_range(3) != 0);

	// reflected check step over one byte
	function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		return c;
	endfunction : step

	// one byte, sometimes followed by an idle cycle
	task automatic put(input logic [7:0] b);
		o_byte = b;
		o_byte_valid = 1'b1;
		@(posedge i_core_clk);
		#1;
		if ($urandom_range(1))
		begin
			o_byte_valid = 1'b0;
			@(posedge i_core_clk);
			#1;
		end
	endtask : put

	// whole frame; bad flips one check bit
	task automatic send(input frame_kind_t k, input logic [3:0] s, input logic [7:0] a,
		input logic bad);
		logic [15:0] c;
		logic [7:0] b;
		logic [7:0] body[$];
		int n;
		// bytes go over unescaped, so no body or check byte may look like a begin or
		// end character; draw the body again until none does
		do
		begin
			body.delete();
			c = 16'hFFFF;
			n = $urandom_range(3);
			for (int i = 0; i < n + 2; i++)
			begin
				b = (i == 0) ? a : 8'($urandom_range(191));
				c = step(c, b);
				body.push_back(b);
			end
			c = ~c ^ {15'h0000, bad};
		end
		while (c[7:1] == 7'h60 || c[15:9] == 7'h60);
		o_active = 1'b1;
		if ($urandom_range(1))
			put(8'hFF);
		put(8'hC0);
		foreach (body[i])
			put(body[i]);
		put(c[7:0]);
		put(c[15:8]);
		o_kind = k;
		o_slot = s;
		o_addr = a;
		put(8'hC1);
		o_byte_valid = 1'b0;
		o_byte = ~o_byte; // released line does not keep its value
		repeat (2) @(posedge i_core_clk);
		#1;
		o_active = 1'b0;
	endtask : send
endmodule : ir_primary_model

// ---- bench/link_fsm_asserts.sv ----
/*
 * Port checker of the secondary link connection block.
 * Assumes it is bound onto ir_secondary_link_fsm and the primary holds
 * rx_active over each frame.
 */
`timescale 1ns/1ps

module link_fsm_asserts #(
	parameter int TIMEOUT_CYCLES = 200
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_rx_byte_valid,
	input wire logic i_rx_active,
	input wire ir_link_pkg::frame_kind_t i_rx_kind,
	input wire logic [ir_link_pkg::SLOT_W-1:0] i_rx_slot,
	input wire logic [7:0] i_rx_conn_addr,
	input wire logic i_tx_ready,
	input wire logic o_tx_valid,
	input wire ir_link_pkg::resp_kind_t o_tx_kind,
	input wire logic [ir_link_pkg::SLOT_W-1:0] o_tx_slot,
	input wire logic [7:0] o_tx_addr,
	input wire logic [15:0] o_link_baud,
	input wire ir_link_pkg::mode_t o_link_mode,
	input wire logic o_dsr_n,
	input wire logic o_frame_err
);
	import ir_link_pkg::*;

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	// ==========================================
	// cycles since any end character; a bad frame restarts it too, so it is only a lower bound
	logic [31:0] quiet;
	logic eof;
	assign eof = i_rx_byte_valid && (i_rx_byte == 8'hC1);
	always_ff @(posedge i_core_clk)
	begin
		if (!i_nrst || eof || o_link_mode == disconnected_state)
			quiet <= 32'h0000_0000;
		else
			quiet <= quiet + 32'h0000_0001;
	end

	// ==========================================
	// properties
	a_halfdup_quiet: assert property (i_rx_active |-> !o_tx_valid)
		else $error("response offered while receiving");
	a_take_drops: assert property (o_tx_valid && i_tx_ready && !i_rx_active |=> !o_tx_valid)
		else $error("response still offered after take");
	a_baud_fixed: assert property (o_link_baud == 16'h2580)
		else $error("link rate not fixed");
	a_slot_two: assert property (o_tx_valid && o_tx_kind == rk_poll_answer |-> o_tx_slot == 4'h2 && o_tx_addr == 8'hFF)
		else $error("poll answer in wrong slot");
	a_dsr_low: assert property (o_link_mode == connected_state ##1 o_link_mode == connected_state |-> !o_dsr_n)
		else $error("ready line high while connected");
	a_dsr_high: assert property (o_link_mode != connected_state [*2] |-> o_dsr_n)
		else $error("ready line low while not connected");
	a_err_pulse: assert property ($rose(o_frame_err) |-> $past(eof, 2) ##1 !o_frame_err)
		else $error("error pulse without end character");
	a_close_drop: assert property (o_tx_valid && i_tx_ready && o_tx_kind == rk_close_confirm |-> ##[1:2] o_link_mode == disconnected_state)
		else $error("close confirmed but link kept");
	a_open_addr: assert property ($rose(o_link_mode == query_state) |-> o_tx_kind == rk_link_ack && o_tx_addr == $past(i_rx_conn_addr))
		else $error("link ack wrong");
	a_data_entry: assert property ($rose(o_link_mode == connected_state) |-> o_tx_kind == rk_data_confirm)
		else $error("connected without data confirm");
	a_silence_bound: assert property (quiet <= TIMEOUT_CYCLES + 8)
		else $error("silent link not dropped");
endmodule : link_fsm_asserts

bind ir_secondary_link_fsm link_fsm_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_asserts (.*);

// ---- bench/testbench.sv ----
/*
 * Self-checking bench of the secondary link connection block.
 * Assumes the primary model drives the receive side and the encoder ready.
 */
`timescale 1ns/1ps

module testbench;
	import ir_link_pkg::*;

	localparam int TMO = 200;
	// idle cycles between polls, a scaled-down stand-in for the primary's poll spacing
	localparam int POLL_GAP = 20;
	logic [14:0] seen;
	logic i_core_clk, i_nrst, i_rx_byte_valid, i_rx_active, i_tx_ready, o_tx_valid;
	logic o_dsr_n, o_frame_err;
	logic [7:0] i_rx_byte, i_rx_conn_addr, o_tx_addr, ca;
	logic [3:0] i_rx_slot, o_tx_slot;
	logic [15:0] o_link_baud;
	frame_kind_t i_rx_kind;
	resp_kind_t o_tx_kind;
	mode_t o_link_mode;
	logic [14:0] q[$];
	int failures = 0, cmp_count = 0, errs = 0, cyc = 0;

	ir_secondary_link_fsm #(.TIMEOUT_CYCLES(TMO)) u_dut (.*);
	ir_primary_model u_pri (.i_core_clk(i_core_clk), .o_byte(i_rx_byte),
		.o_byte_valid(i_rx_byte_valid), .o_active(i_rx_active), .o_kind(i_rx_kind),
		.o_slot(i_rx_slot), .o_addr(i_rx_conn_addr), .o_ready(i_tx_ready));

	// ==========================================
	// clock, hang limit, verdict
	initial i_core_clk = 1'b0;
	always #2.5 i_core_clk = ~i_core_clk;

	task automatic conclude();
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// hang limit: a run that outlives its budget counts as a mismatch
	always @(posedge i_core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			conclude();
		end
	end

	// watcher: every taken response against the oldest note
	always @(posedge i_core_clk)
	begin
		if (o_frame_err === 1'b1)
			errs++;
		if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1)
		begin
			seen = {o_tx_kind, (o_tx_kind == rk_poll_answer) ? o_tx_slot : 4'h0, o_tx_addr};
			if (q.size() == 0)
				chk(16'h0001, 16'h0000);
			else
				chk(16'(seen), 16'(q.pop_front()));
		end
	end

	// ==========================================
	// one frame, its expected answer and mode
	task automatic frm(input frame_kind_t k, input logic [3:0] s, input logic [7:0] a,
		input logic bad, input logic e, input resp_kind_t rk, input mode_t m);
		int n;
		if (e)
			q.push_back({rk, (rk == rk_poll_answer) ? 4'h2 : 4'h0, a});
		u_pri.send(k, s, a, bad);
		for (n = 0; n < 60 && q.size() != 0; n++)
			@(posedge i_core_clk);
		repeat (4) @(posedge i_core_clk);
		#1;
		chk(16'(q.size()), 16'h0000);
		chk(16'(o_link_mode), 16'(m));
	endtask : frm

	task automatic polls(input int last);
		for (int s = 0; s <= last; s++)
		begin
			repeat (POLL_GAP) @(posedge i_core_clk);
			#1;
			frm(fk_poll, 4'(s), 8'hFF, 1'b0, s == 2, rk_poll_answer,
				(s < 2) ? disconnected_state : answered_state);
		end
	endtask : polls

	task automatic connect(input logic [7:0] a);
		frm(fk_bcast_id, 4'h0, a, 1'b0, 1'b0, rk_data, link_init_state);
		frm(fk_open_link, 4'h0, a, 1'b0, 1'b1, rk_link_ack, query_state);
		frm(fk_open_query, 4'h0, a, 1'b0, 1'b1, rk_query_confirm, query_state);
		for (int i = 0; i < 3; i++)
			frm(fk_query, 4'h0, a, 1'b0, 1'b1, rk_query_answer, query_state);
		frm(fk_open_data, 4'h0, a, 1'b0, 1'b1, rk_data_confirm, connected_state);
		chk(16'(o_dsr_n), 16'h0000);
	endtask : connect

	// ==========================================
	// main sequence
	initial
	begin
		i_nrst = 1'b0;
		void'($urandom(12687));
		repeat (8) @(posedge i_core_clk);
		#1;
		i_nrst = 1'b1;
		chk(16'(o_link_mode), 16'(disconnected_state));
		chk(16'(o_dsr_n), 16'h0001);
		chk(o_link_baud, 16'h2580);
		polls(5);
		frm(fk_poll, 4'h2, 8'hFF, 1'b0, 1'b0, rk_poll_answer, answered_state);
		ca = 8'($urandom_range(191));
		frm(fk_open_link, 4'h0, ca, 1'b0, 1'b0, rk_data, answered_state);
		frm(fk_bcast_id, 4'h0, ca, 1'b1, 1'b0, rk_data, answered_state);
		chk(16'(errs), 16'h0001);
		connect(ca);
		for (int i = 0; i < 4; i++)
			frm(fk_data, 4'h0, ca, 1'b0, 1'b1, rk_data, connected_state);
		frm(fk_other, 4'h0, ca, 1'b0, 1'b1, rk_data, connected_state);
		frm(fk_poll, 4'h0, 8'hFF, 1'b0, 1'b0, rk_data, connected_state);
		frm(fk_close, 4'h0, ca, 1'b0, 1'b1, rk_close_confirm, disconnected_state);
		chk(16'(o_dsr_n), 16'h0001);
		polls(3);
		ca = 8'($urandom_range(191));
		connect(ca);
		// silence: still up well before the limit, gone shortly after it
		repeat (TMO - 40) @(posedge i_core_clk);
		#1;
		chk(16'(o_link_mode), 16'(connected_state));
		repeat (80) @(posedge i_core_clk);
		#1;
		chk(16'(o_link_mode), 16'(disconnected_state));
		chk(16'(o_dsr_n), 16'h0001);
		chk(16'(errs), 16'h0001);
		conclude();
	end
endmodule : testbench

// ---- hdl/ir_frame_checker.sv ----
/*
 * Receive framing checker: hunts begin characters, ends on the end character
 * and checks the frame check sequence over everything between them.
 * Assumes bytes arrive already decoded from the optical receiver, one per strobe.
 */
`timescale 1ns/1ps
`include "ir_link_params.svh"

module ir_frame_checker (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_byte,
	input wire logic i_byte_valid,
	output logic o_in_frame,
	output logic o_ok,
	output logic o_err
);
	import ir_link_pkg::*;

	chk_state_t st;
	chk_state_t next_st;

	// ==========================================================
	// reflected byte update, low bit first as it goes over the air
	function automatic logic [15:0] fcs_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
		begin
			c = c[0] ? ((c >> 1) ^ `IR_FCS_POLY) : (c >> 1);
		end
		return c;
	endfunction : fcs_step

	// ==========================================================
	// framing sequence
	always_comb
	begin
		next_st = st;
		next_st.ok = 1'b0;
		next_st.err = 1'b0;
		if (i_byte_valid)
		begin
			if (i_byte == `IR_BOF)
			begin
				// a repeated begin character just restarts the frame
				next_st.in_frame = 1'b1;
				next_st.crc = `IR_FCS_INIT;
				next_st.count = 3'h0;
			end
			else if (!st.in_frame)
			begin
				// extra 0xFF fill and noise are ignored until a 0xC0
				next_st.in_frame = 1'b0;
			end
			else if (i_byte == `IR_EOF)
			begin
				// residue check covers the sequence sent low byte first
				next_st.in_frame = 1'b0;
				if ((st.count >= `IR_MIN_FRAME_BYTES) && (st.crc == `IR_FCS_GOOD))
				begin
					next_st.ok = 1'b1;
				end
				else
				begin
					next_st.err = 1'b1;
				end
			end
			else
			begin
				next_st.crc = fcs_step(st.crc, i_byte);
				if (st.count != 3'h7)
				begin
					next_st.count = st.count + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_nrst)
		begin
			st <= '{in_frame: 1'b0, crc: `IR_FCS_INIT, count: 3'h0, ok: 1'b0, err: 1'b0};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign o_in_frame = st.in_frame;
	assign o_ok = st.ok;
	assign o_err = st.err;

endmodule : ir_frame_checker

// ---- hdl/ir_link_params.svh ----
/*
 * Constants of the infrared secondary link connection block: framing characters,
 * frame check sequence, timeslot, rates and timing counts.
 * Assumes it is included by bare name from every design file that needs it.
 */
// Functional notes
// - polling before connection runs at the default 9600 baud on both stations
// - secondary answers after exactly one numbered poll; its number is the timeslot
// - this device always answers poll number 2 and holds timeslot 2
// - keep answering every new poll series even with nothing to send
// - discovery starts only after our poll answer and the broadcast id
// - primary sends link parameters first, we reply; common rate is 9.6 kbaud
// - link opens with parameterised open command; we answer acknowledge on its address
// - query channel opened and confirmed, then data channel opened and confirmed
// - answer every information query: service name, address, capabilities
// - data-set-ready output driven low during normal response operation
// - while connected check frames for errors and keep exchanging empty packets
// - close command is confirmed and both stations return to disconnected
// - without close, fall back to disconnected after timeout since last frame
// - half duplex: never transmit while receiving, exchange ordered to avoid collision
// - device acts only as the single secondary of a point-to-point link
// - frames start with 0xC0 begin characters; extra ones may be 0xFF
// - every frame ends with end character 0xC1
// - 16-bit check sequence, low byte first, over address, control, information
`ifndef IR_LINK_PARAMS_SVH
`define IR_LINK_PARAMS_SVH

// ==========================================================
// rates and clock
`define IR_CLK_HZ 200000000
`define IR_BAUD 9600
`define IR_REPLY_SLOT 2
`define IR_POLL_SPACING_MS 70

// ==========================================================
// framing characters
`define IR_BOF 8'hC0
`define IR_BOF_EXTRA 8'hFF
`define IR_EOF 8'hC1
`define IR_MIN_FRAME_BYTES 3'h4

// ==========================================================
// frame check sequence, reflected update, residue checked over the whole frame
`define IR_FCS_POLY 16'h8408
`define IR_FCS_INIT 16'hFFFF
`define IR_FCS_GOOD 16'hF0B8

// ==========================================================
// addresses and reset values
`define IR_BCAST_ADDR 8'hFF
`define IR_ADDR_RESET 8'h00
`define IR_SLOT_RESET 4'h0

// ==========================================================
// timing
`define IR_TIMEOUT_MS 3000
`define IR_TIMEOUT_CYCLES (`IR_TIMEOUT_MS * (`IR_CLK_HZ / 1000))

`endif

// ---- hdl/ir_link_pkg.sv ----
/*
 * Types of the infrared secondary link connection block.
 * Assumes the frame decoder outside classifies each frame into frame_kind_t.
 */
package ir_link_pkg;

	localparam int SLOT_W = 4;

	// link modes of the secondary
	typedef enum logic [2:0] {
		disconnected_state = 3'b000,
		answered_state = 3'b001,
		link_init_state = 3'b010,
		query_state = 3'b011,
		connected_state = 3'b100
	} mode_t;

	// kinds of frames received from the primary
	typedef enum logic [3:0] {
		fk_poll = 4'b0000,
		fk_bcast_id = 4'b0001,
		fk_open_link = 4'b0010,
		fk_open_query = 4'b0011,
		fk_query = 4'b0100,
		fk_open_data = 4'b0101,
		fk_data = 4'b0110,
		fk_close = 4'b0111,
		fk_other = 4'b1000
	} frame_kind_t;

	// kinds of responses this station sends
	typedef enum logic [2:0] {
		rk_poll_answer = 3'b000,
		rk_link_ack = 3'b001,
		rk_query_confirm = 3'b010,
		rk_query_answer = 3'b011,
		rk_data_confirm = 3'b100,
		rk_data = 3'b101,
		rk_close_confirm = 3'b110
	} resp_kind_t;

	typedef struct packed {
		mode_t mode;
		logic answered;
		logic pending;
		resp_kind_t tx_kind;
		logic [7:0] tx_addr;
		logic [SLOT_W-1:0] tx_slot;
		logic [7:0] conn_addr;
		logic closing;
		logic dsr_n;
		logic frame_err;
	} fsm_state_t;

	typedef struct packed {
		logic in_frame;
		logic [15:0] crc;
		logic [2:0] count;
		logic ok;
		logic err;
	} chk_state_t;

	typedef struct packed {
		logic [31:0] count;
		logic expired;
	} tmr_state_t;

endpackage : ir_link_pkg

// ---- hdl/ir_secondary_link_fsm.sv ----
/*
 * Connection manager of an infrared secondary station: answers polls in its
 * timeslot, walks link setup and service queries, keeps the connection alive
 * and drops it on close or silence.
 * Assumes an outside decoder supplies bytes, and with each end character the
 * frame kind, poll number and connection address of that frame; an outside
 * encoder sends each requested response with framing and check sequence.
 */
`timescale 1ns/1ps
`include "ir_link_params.svh"

module ir_secondary_link_fsm #(
	parameter int REPLY_SLOT = `IR_REPLY_SLOT,
	parameter int BAUD = `IR_BAUD,
	parameter int TIMEOUT_CYCLES = `IR_TIMEOUT_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_rx_byte_valid,
	input wire logic i_rx_active,
	input wire ir_link_pkg::frame_kind_t i_rx_kind,
	input wire logic [ir_link_pkg::SLOT_W-1:0] i_rx_slot,
	input wire logic [7:0] i_rx_conn_addr,
	input wire logic i_tx_ready,
	output logic o_tx_valid,
	output ir_link_pkg::resp_kind_t o_tx_kind,
	output logic [ir_link_pkg::SLOT_W-1:0] o_tx_slot,
	output logic [7:0] o_tx_addr,
	output logic [15:0] o_link_baud,
	output ir_link_pkg::mode_t o_link_mode,
	output logic o_dsr_n,
	output logic o_frame_err
);
	import ir_link_pkg::*;

	localparam logic [SLOT_W-1:0] MY_SLOT = SLOT_W'(REPLY_SLOT);
	localparam logic [SLOT_W-1:0] FIRST_SLOT = `IR_SLOT_RESET;

	fsm_state_t st;
	fsm_state_t next_st;
	logic rx_in_frame;
	logic rx_ok;
	logic rx_err;
	logic line_busy;
	logic tx_take;
	logic silence;
	logic timer_run;

	// ==========================================================
	// elaboration checks
	generate
		if ((REPLY_SLOT < 0) || (REPLY_SLOT >= (1 << SLOT_W)))
		begin : g_bad_slot
			$error("reply slot does not fit the poll number field");
		end
		if (BAUD != `IR_BAUD)
		begin : g_bad_baud
			$error("this station only runs at the default rate");
		end
	endgenerate

	// ==========================================================
	// receive framing and silence supervision
	ir_frame_checker u_checker (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_byte(i_rx_byte),
		.i_byte_valid(i_rx_byte_valid),
		.o_in_frame(rx_in_frame),
		.o_ok(rx_ok),
		.o_err(rx_err)
	);

	// armed in every mode but disconnected, and not while a close is pending, so a stalled discovery also falls back
	assign timer_run = (st.mode != disconnected_state) && !st.closing;

	ir_silence_timer #(
		.TIMEOUT_CYCLES(TIMEOUT_CYCLES)
	) u_timer (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_run(timer_run),
		.i_restart(rx_ok),
		.o_expired(silence)
	);

	// ==========================================================
	// half duplex gate: the response waits while anything is being received
	assign line_busy = i_rx_active || rx_in_frame;
	assign o_tx_valid = st.pending && !line_busy;
	assign tx_take = o_tx_valid && i_tx_ready;

	// ==========================================================
	// connection sequence
	always_comb
	begin
		next_st = st;
		next_st.frame_err = 1'b0;

		// a handed-over response frees the slot; a confirmed close ends the link
		if (tx_take)
		begin
			next_st.pending = 1'b0;
			if (st.closing)
			begin
				next_st.closing = 1'b0;
				next_st.mode = disconnected_state;
				next_st.answered = 1'b0;
			end
		end

		// bad frames are reported and never restart the silence wait
		if (rx_err)
		begin
			next_st.frame_err = 1'b1;
		end

		if (rx_ok && !st.closing)
		begin
			if (i_rx_kind == fk_close && st.mode != disconnected_state
				&& st.mode != answered_state)
			begin
				// confirm the close, then drop once the confirm is taken
				next_st.pending = 1'b1;
				next_st.tx_kind = rk_close_confirm;
				next_st.tx_addr = st.conn_addr;
				next_st.closing = 1'b1;
			end
			else
			begin
				unique case (st.mode)
					disconnected_state, answered_state, link_init_state:
					begin
						if (i_rx_kind == fk_poll)
						begin
							// poll 0 opens a new series that must be answered again
							if (i_rx_slot == FIRST_SLOT)
							begin
								next_st.answered = 1'b0;
								next_st.mode = disconnected_state;
							end
							// exactly one answer per series, always in our slot
							if (i_rx_slot == MY_SLOT
								&& (st.answered == 1'b0 || i_rx_slot == FIRST_SLOT))
							begin
								next_st.answered = 1'b1;
								next_st.mode = answered_state;
								next_st.pending = 1'b1;
								next_st.tx_kind = rk_poll_answer;
								next_st.tx_slot = i_rx_slot;
								next_st.tx_addr = `IR_BCAST_ADDR;
							end
						end
						else if (i_rx_kind == fk_bcast_id && st.mode == answered_state)
						begin
							// discovery only after our answer and the broadcast id
							next_st.mode = link_init_state;
						end
						else if (i_rx_kind == fk_open_link && st.mode == link_init_state)
						begin
							// reply with our parameters on the given address
							next_st.conn_addr = i_rx_conn_addr;
							next_st.pending = 1'b1;
							next_st.tx_kind = rk_link_ack;
							next_st.tx_addr = i_rx_conn_addr;
							next_st.mode = query_state;
						end
					end
					query_state:
					begin
						if (i_rx_kind == fk_open_query)
						begin
							next_st.pending = 1'b1;
							next_st.tx_kind = rk_query_confirm;
							next_st.tx_addr = st.conn_addr;
						end
						else if (i_rx_kind == fk_query)
						begin
							next_st.pending = 1'b1;
							next_st.tx_kind = rk_query_answer;
							next_st.tx_addr = st.conn_addr;
						end
						else if (i_rx_kind == fk_open_data)
						begin
							next_st.pending = 1'b1;
							next_st.tx_kind = rk_data_confirm;
							next_st.tx_addr = st.conn_addr;
							next_st.mode = connected_state;
						end
					end
					connected_state:
					begin
						// every frame but a poll or broadcast id gets a reply, empty or not, to prove the link
						if (i_rx_kind != fk_poll && i_rx_kind != fk_bcast_id)
						begin
							next_st.pending = 1'b1;
							next_st.tx_kind = rk_data;
							next_st.tx_addr = st.conn_addr;
						end
					end
					default:
					begin
						next_st.mode = disconnected_state;
					end
				endcase
			end
		end

		// silence since the last good frame drops whatever was in progress
		if (silence)
		begin
			next_st.mode = disconnected_state;
			next_st.answered = 1'b0;
			next_st.pending = 1'b0;
			next_st.closing = 1'b0;
		end

		// data set ready low only in normal response operation
		next_st.dsr_n = (next_st.mode != connected_state);
	end

	// ==========================================================
	// state register
	always_ff @(posedge i_core_clk)
	begin
		if (!i_nrst)
		begin
			st <= '{
				mode: disconnected_state,
				answered: 1'b0,
				pending: 1'b0,
				tx_kind: rk_poll_answer,
				tx_addr: `IR_ADDR_RESET,
				tx_slot: `IR_SLOT_RESET,
				conn_addr: `IR_ADDR_RESET,
				closing: 1'b0,
				dsr_n: 1'b1,
				frame_err: 1'b0
			};
		end
		else
		begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs; only the secondary role exists, so there is no role select
	assign o_tx_kind = st.tx_kind;
	assign o_tx_slot = st.tx_slot;
	assign o_tx_addr = st.tx_addr;
	assign o_link_baud = 16'(BAUD); // advertised in the link acknowledge
	assign o_link_mode = st.mode;
	assign o_dsr_n = st.dsr_n;
	assign o_frame_err = st.frame_err;

endmodule : ir_secondary_link_fsm

// ---- hdl/ir_silence_timer.sv ----
/*
 * Silence timer: counts cycles since the last good frame and pulses on expiry.
 * Assumes restart pulses only on frames that passed the check.
 */
`timescale 1ns/1ps
`include "ir_link_params.svh"

module ir_silence_timer #(
	parameter int TIMEOUT_CYCLES = `IR_TIMEOUT_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_run,
	input wire logic i_restart,
	output logic o_expired
);
	import ir_link_pkg::*;

	localparam logic [31:0] LAST = 32'(TIMEOUT_CYCLES - 1);

	tmr_state_t st;
	tmr_state_t next_st;

	generate
		if (TIMEOUT_CYCLES < 1)
		begin : g_bad_timeout
			$error("timeout must be at least one cycle");
		end
	endgenerate

	// ==========================================================
	// count only while armed; a good frame starts the wait again
	always_comb
	begin
		next_st = st;
		next_st.expired = 1'b0;
		if (!i_run || i_restart)
		begin
			next_st.count = 32'h0000_0000;
		end
		else if (st.count == LAST)
		begin
			next_st.expired = 1'b1;
			next_st.count = 32'h0000_0000;
		end
		else
		begin
			next_st.count = st.count + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_nrst)
		begin
			st <= '{count: 32'h0000_0000, expired: 1'b0};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign o_expired = st.expired;

endmodule : ir_silence_timer
